// ===== eep_i2c_page.sv
// Purpose: two-wire slave of a 128-byte EEPROM, bi-directional mode only
// Assumes: scl/sda/protect pins are asynchronous and pass two flip-flops
// Notes:   write bytes pass an 8-entry FIFO; SCL is stretched when it fills
//
// Function
// - page write opens: start, address, word address
// - up to 16 bytes, one programming cycle
// - ack data, bump only low pointer bits
// - over sixteen bytes wraps, later bytes replace
// - programming starts only on stop
// - no address ack while programming
// - protect pin low: memory read-only
// - read direction bit is one
// - counter is last location plus one
// - location 127 wraps to 0
// - random read: dummy write, restart, read
// - sequential read follows either read kind
// - each master ack sends next byte
// - sequential read wraps at top of memory
// - nack then stop ends data output
// - address byte: type, three ignored, direction
// - first scl fall enters bi-directional mode
`timescale 1ns/1ps

module eep_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [CNT_W-1:0]            count;
    } eep_fifo_state_type;

    eep_fifo_state_type state_reg;
    eep_fifo_state_type state_next;

    logic push;
    logic pop;

    // pointers wrap by explicit compare so depth need not be a power of two
    always_comb begin
        state_next = state_reg;
        in_ready   = (state_reg.count != CNT_W'(DEPTH));
        out_valid  = (state_reg.count != '0);
        out_data   = state_reg.mem[state_reg.rd_ptr];
        push       = in_valid & in_ready;
        pop        = out_valid & out_ready;
        if (push) begin
            state_next.mem[state_reg.wr_ptr] = in_data;
            if (state_reg.wr_ptr == PTR_W'(DEPTH - 1)) begin
                state_next.wr_ptr = '0;
            end else begin
                state_next.wr_ptr = state_reg.wr_ptr + PTR_W'(1);
            end
        end
        if (pop) begin
            if (state_reg.rd_ptr == PTR_W'(DEPTH - 1)) begin
                state_next.rd_ptr = '0;
            end else begin
                state_next.rd_ptr = state_reg.rd_ptr + PTR_W'(1);
            end
        end
        if (push && !pop) begin
            state_next.count = state_reg.count + CNT_W'(1);
        end else if (pop && !push) begin
            state_next.count = state_reg.count - CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : eep_fifo

module eep_i2c_page #(
    parameter int         PROG_CYCLES = eep_pkg::PROG_CYCLES_DEF,
    parameter logic [3:0] DEV_TYPE    = eep_pkg::DEV_TYPE_DEF,
    parameter int         FIFO_DEPTH  = eep_pkg::FIFO_DEPTH
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic scl_i,
    output logic      scl_o,
    output logic      scl_oe_n,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n,
    input  wire logic transmit_only_clock_pin,
    output logic      bidir_mode,
    output logic      prog_busy
);
    typedef struct packed {
        logic                     scl_s1;
        logic                     scl_s2;
        logic                     scl_d;
        logic                     sda_s1;
        logic                     sda_s2;
        logic                     sda_d;
        logic                     wp_s1;
        logic                     wp_s2;
        logic                     bidir;
        eep_pkg::eep_phase_type   phase;
        eep_pkg::eep_kind_type    kind;
        logic                     rd_mode;
        logic                     tx_more;
        logic [eep_pkg::BYTE_W-1:0] shreg;
        logic [3:0]               bit_cnt;
        logic [eep_pkg::ADDR_W-1:0] ptr;
        logic                     data_seen;
        logic                     inhibit;
        logic                     commit_pending;
        logic                     busy;
        logic [31:0]              timer;
        logic [eep_pkg::PAGE_BYTES-1:0][eep_pkg::BYTE_W-1:0] page;
        logic [eep_pkg::PAGE_BYTES-1:0] page_valid;
        logic [eep_pkg::MEM_DEPTH-1:0][eep_pkg::BYTE_W-1:0] mem;
        logic                     scl_oe_n;
        logic                     sda_oe_n;
        logic                     scl_o;
        logic                     sda_o;
    } eep_state_type;

    eep_state_type state_reg;
    eep_state_type state_next;

    logic                       push_valid;
    logic                       push_ready;
    eep_pkg::eep_wr_entry_type  push_entry;
    logic                       pop_valid;
    logic                       pop_ready;
    eep_pkg::eep_wr_entry_type  pop_entry;
    logic [eep_pkg::WR_ENTRY_W-1:0] pop_bits;

    eep_fifo #(
        .WIDTH (eep_pkg::WR_ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_entry),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_bits)
    );

    assign pop_entry = pop_bits;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic byte_done;

    always_comb begin
        state_next = state_reg;
        push_valid = 1'b0;
        push_entry = '0;
        pop_ready  = 1'b0;

        // two-flop synchronisers, then a third stage for edges
        state_next.scl_s1 = scl_i;
        state_next.scl_s2 = state_reg.scl_s1;
        state_next.scl_d  = state_reg.scl_s2;
        state_next.sda_s1 = sda_i;
        state_next.sda_s2 = state_reg.sda_s1;
        state_next.sda_d  = state_reg.sda_s2;
        state_next.wp_s1  = transmit_only_clock_pin;
        state_next.wp_s2  = state_reg.wp_s1;

        scl_rise   = state_reg.scl_s2 & ~state_reg.scl_d;
        scl_fall   = ~state_reg.scl_s2 & state_reg.scl_d;
        start_seen = state_reg.scl_s2 & state_reg.scl_d &
                     ~state_reg.sda_s2 & state_reg.sda_d;
        stop_seen  = state_reg.scl_s2 & state_reg.scl_d &
                     state_reg.sda_s2 & ~state_reg.sda_d;
        byte_done  = (scl_fall | ~state_reg.scl_oe_n) &
                     (state_reg.bit_cnt == eep_pkg::BITS_PER_BYTE);

        // drain into the page buffer; held off while the page is committed
        pop_ready = ~state_reg.busy & ~state_reg.commit_pending;
        if (pop_valid && pop_ready) begin
            state_next.page[pop_entry.offs]       = pop_entry.data;
            state_next.page_valid[pop_entry.offs] = 1'b1;
        end

        // commit waits until every acked byte has left the FIFO
        if (state_reg.commit_pending && !pop_valid) begin
            for (int i = 0; i < eep_pkg::PAGE_BYTES; i++) begin
                if (state_reg.page_valid[i]) begin
                    state_next.mem[{state_reg.ptr[eep_pkg::ADDR_W-1:
                                   eep_pkg::PAGE_W], i[eep_pkg::PAGE_W-1:0]}]
                        = state_reg.page[i];
                end
            end
            state_next.page_valid     = '0;
            state_next.commit_pending = 1'b0;
            state_next.busy           = 1'b1;
            state_next.timer          = eep_pkg::TIMER_ZERO;
        end

        if (state_reg.busy) begin
            state_next.timer = state_reg.timer + eep_pkg::TIMER_STEP;
            if (state_reg.timer == 32'(PROG_CYCLES - 1)) begin
                state_next.busy = 1'b0;
            end
        end

        if (!state_reg.bidir) begin
            if (scl_fall) begin
                state_next.bidir = 1'b1;
            end
        end else if (stop_seen) begin
            state_next.phase    = eep_pkg::ST_IDLE;
            state_next.sda_oe_n = 1'b1;
            state_next.scl_oe_n = 1'b1;
            // protect level is checked up to the stop itself
            if (state_reg.data_seen && !state_reg.inhibit &&
                state_reg.wp_s2) begin
                state_next.commit_pending = 1'b1;
            end
            state_next.data_seen = 1'b0;
            state_next.inhibit   = 1'b0;
        end else if (start_seen) begin
            state_next.phase     = eep_pkg::ST_RX;
            state_next.kind      = eep_pkg::KIND_DEV;
            state_next.bit_cnt   = eep_pkg::BIT_CNT_ZERO;
            state_next.sda_oe_n  = 1'b1;
            state_next.scl_oe_n  = 1'b1;
            state_next.data_seen = 1'b0;
            state_next.inhibit   = 1'b0;
        end else begin
            case (state_reg.phase)
                eep_pkg::ST_RX: begin
                    if (!state_reg.wp_s2) begin
                        state_next.inhibit = 1'b1;
                    end
                    if (scl_rise &&
                        state_reg.bit_cnt != eep_pkg::BITS_PER_BYTE) begin
                        state_next.shreg = {state_reg.shreg[eep_pkg::BYTE_NEXT:0],
                                            state_reg.sda_s2};
                        state_next.bit_cnt = state_reg.bit_cnt +
                                             eep_pkg::BIT_CNT_STEP;
                    end
                    if (byte_done) begin
                        case (state_reg.kind)
                            eep_pkg::KIND_DEV: begin
                                if (state_reg.shreg[eep_pkg::DEV_TYPE_MSB:
                                    eep_pkg::DEV_TYPE_LSB] == DEV_TYPE &&
                                    !state_reg.busy &&
                                    !state_reg.commit_pending) begin
                                    state_next.sda_oe_n = 1'b0;
                                    state_next.phase    = eep_pkg::ST_RX_ACK;
                                    state_next.rd_mode  =
                                        state_reg.shreg[eep_pkg::RW_BIT];
                                end else begin
                                    state_next.phase = eep_pkg::ST_WAIT;
                                end
                            end
                            eep_pkg::KIND_WORD: begin
                                state_next.ptr =
                                    state_reg.shreg[eep_pkg::ADDR_W-1:0];
                                state_next.page_valid = '0;
                                state_next.sda_oe_n   = 1'b0;
                                state_next.phase      = eep_pkg::ST_RX_ACK;
                            end
                            eep_pkg::KIND_DATA: begin
                                // a full FIFO holds SCL low instead of losing data
                                if (push_ready) begin
                                    push_valid      = 1'b1;
                                    push_entry.offs =
                                        state_reg.ptr[eep_pkg::PAGE_W-1:0];
                                    push_entry.data = state_reg.shreg;
                                    state_next.ptr[eep_pkg::PAGE_W-1:0] =
                                        state_reg.ptr[eep_pkg::PAGE_W-1:0] +
                                        eep_pkg::PAGE_STEP;
                                    state_next.data_seen = 1'b1;
                                    state_next.sda_oe_n  = 1'b0;
                                    state_next.scl_oe_n  = 1'b1;
                                    state_next.phase     = eep_pkg::ST_RX_ACK;
                                end else begin
                                    state_next.scl_oe_n = 1'b0;
                                end
                            end
                            default: begin
                                state_next.phase = eep_pkg::ST_WAIT;
                            end
                        endcase
                    end
                end
                eep_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        state_next.sda_oe_n = 1'b1;
                        state_next.bit_cnt  = eep_pkg::BIT_CNT_ZERO;
                        state_next.phase    = eep_pkg::ST_RX;
                        if (state_reg.kind == eep_pkg::KIND_DEV &&
                            state_reg.rd_mode) begin
                            state_next.shreg = state_reg.mem[state_reg.ptr];
                            state_next.ptr   = state_reg.ptr +
                                               eep_pkg::PTR_STEP;
                            state_next.sda_oe_n =
                                state_reg.mem[state_reg.ptr][eep_pkg::BYTE_MSB];
                            state_next.phase = eep_pkg::ST_TX;
                        end else if (state_reg.kind == eep_pkg::KIND_DEV) begin
                            state_next.kind = eep_pkg::KIND_WORD;
                        end else begin
                            state_next.kind = eep_pkg::KIND_DATA;
                        end
                    end
                end
                eep_pkg::ST_TX: begin
                    if (scl_fall) begin
                        state_next.bit_cnt = state_reg.bit_cnt +
                                             eep_pkg::BIT_CNT_STEP;
                        state_next.shreg = {state_reg.shreg[eep_pkg::BYTE_NEXT:0],
                                            1'b1};
                        state_next.sda_oe_n =
                            state_reg.shreg[eep_pkg::BYTE_NEXT];
                        if (state_reg.bit_cnt == eep_pkg::TX_LAST_BIT) begin
                            state_next.sda_oe_n = 1'b1;
                            state_next.tx_more  = 1'b0;
                            state_next.phase    = eep_pkg::ST_TX_ACK;
                        end
                    end
                end
                eep_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        state_next.tx_more = ~state_reg.sda_s2;
                    end
                    if (scl_fall) begin
                        if (state_reg.tx_more) begin
                            state_next.shreg = state_reg.mem[state_reg.ptr];
                            state_next.ptr   = state_reg.ptr +
                                               eep_pkg::PTR_STEP;
                            state_next.sda_oe_n =
                                state_reg.mem[state_reg.ptr][eep_pkg::BYTE_MSB];
                            state_next.bit_cnt = eep_pkg::BIT_CNT_ZERO;
                            state_next.phase   = eep_pkg::ST_TX;
                        end else begin
                            state_next.phase = eep_pkg::ST_WAIT;
                        end
                    end
                end
                default: begin
                    state_next.sda_oe_n = 1'b1;
                    state_next.scl_oe_n = 1'b1;
                end
            endcase
        end

        state_next.sda_o = 1'b0;
        state_next.scl_o = 1'b0;
    end

    // memory contents survive reset; only control state is cleared
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg          <= state_next;
            state_reg.scl_s1   <= 1'b1;
            state_reg.scl_s2   <= 1'b1;
            state_reg.scl_d    <= 1'b1;
            state_reg.sda_s1   <= 1'b1;
            state_reg.sda_s2   <= 1'b1;
            state_reg.sda_d    <= 1'b1;
            state_reg.wp_s1    <= 1'b1;
            state_reg.wp_s2    <= 1'b1;
            state_reg.bidir    <= 1'b0;
            state_reg.phase    <= eep_pkg::ST_IDLE;
            state_reg.kind     <= eep_pkg::KIND_DEV;
            state_reg.rd_mode  <= 1'b0;
            state_reg.tx_more  <= 1'b0;
            state_reg.shreg    <= '0;
            state_reg.bit_cnt  <= eep_pkg::BIT_CNT_ZERO;
            state_reg.ptr      <= '0;
            state_reg.data_seen      <= 1'b0;
            state_reg.inhibit        <= 1'b0;
            state_reg.commit_pending <= 1'b0;
            state_reg.busy     <= 1'b0;
            state_reg.timer    <= eep_pkg::TIMER_ZERO;
            state_reg.page_valid <= '0;
            state_reg.scl_oe_n <= 1'b1;
            state_reg.sda_oe_n <= 1'b1;
            state_reg.scl_o    <= 1'b0;
            state_reg.sda_o    <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign scl_o      = state_reg.scl_o;
    assign scl_oe_n   = state_reg.scl_oe_n;
    assign sda_o      = state_reg.sda_o;
    assign sda_oe_n   = state_reg.sda_oe_n;
    assign bidir_mode = state_reg.bidir;
    assign prog_busy  = state_reg.busy;

endmodule : eep_i2c_page

// ===== eep_pkg.sv
// Purpose: shared constants and types for the two-wire page-write EEPROM
// Assumes: sys_clk at 40 MHz, one clock domain
// Notes:   all widths, counts and encodings of the block live here
package eep_pkg;

    localparam int ADDR_W      = 7;
    localparam int MEM_DEPTH   = 128;
    localparam int BYTE_W      = 8;
    localparam int PAGE_W      = 4;
    localparam int PAGE_BYTES  = 16;
    localparam int FIFO_DEPTH  = 8;

    // bit positions inside the device address byte
    localparam int RW_BIT       = 0;
    localparam int DEV_TYPE_LSB = 4;
    localparam int DEV_TYPE_MSB = 7;
    localparam int BYTE_MSB     = 7;
    localparam int BYTE_NEXT    = 6;

    // device-type code, value is arbitrary
    localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TX_LAST_BIT   = 4'h7;
    localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
    localparam logic [3:0] BIT_CNT_STEP  = 4'h1;
    localparam logic [ADDR_W-1:0] PTR_STEP  = 7'h01;
    localparam logic [PAGE_W-1:0] PAGE_STEP = 4'h1;

    // self-timed programming time
    localparam int WRITE_CYCLE_MS  = 5;
    localparam int CLK_HZ          = 40_000_000;
    localparam int PROG_CYCLES_DEF = WRITE_CYCLE_MS * (CLK_HZ / 1000);
    localparam logic [31:0] TIMER_STEP = 32'h0000_0001;
    localparam logic [31:0] TIMER_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [PAGE_W-1:0] offs;
        logic [BYTE_W-1:0] data;
    } eep_wr_entry_type;

    localparam int WR_ENTRY_W = $bits(eep_wr_entry_type);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WAIT
    } eep_phase_type;

    typedef enum logic [1:0] {
        KIND_DEV,
        KIND_WORD,
        KIND_DATA
    } eep_kind_type;

endpackage : eep_pkg

// ===== eep_i2c_page_assertions.sv
// Purpose: pin-level assertions for the two-wire page-write EEPROM
// Assumes: one clock domain, synchronous active-low reset
// Notes:   helpers watch raw pins, so windows allow for sync latency
`timescale 1ns/1ps
module eep_i2c_page_assertions #(
    parameter int PROG_CYCLES = 50
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic transmit_only_clock_pin,
    input wire logic bidir_mode,
    input wire logic prog_busy
);
    logic [31:0] cnt_reg;
    logic [5:0]  age_reg;
    logic        sda_d_reg;
    logic        prot_reg;
    wire         start = scl_i & ~sda_i & sda_d_reg;
    wire         stop  = scl_i & sda_i & ~sda_d_reg;
    // age saturates so a long-idle bus cannot alias a fresh stop
    always_ff @(posedge sys_clk) begin
        sda_d_reg <= sda_i;
        cnt_reg   <= (resetn && prog_busy) ? cnt_reg + 32'h1 : 32'h0;
        age_reg   <= !resetn ? 6'h3F : stop ? 6'h00
                     : age_reg + {5'h00, age_reg != 6'h3F};
        prot_reg  <= resetn & (~transmit_only_clock_pin | (prot_reg & ~start));
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_reset_idle;
        disable iff (1'b0)
        !resetn |=> sda_oe_n && scl_oe_n && !bidir_mode && !prog_busy;
    endproperty
    property p_drive_low; scl_o == 1'b0 && sda_o == 1'b0; endproperty
    property p_mode_sticky; bidir_mode |=> bidir_mode; endproperty
    property p_quiet_early; !bidir_mode |-> sda_oe_n; endproperty
    property p_prog_len;
        $fell(prog_busy) |-> cnt_reg == 32'(PROG_CYCLES);
    endproperty
    property p_busy_on_stop; $rose(prog_busy) |-> age_reg < 6'h28; endproperty
    property p_busy_quiet; prog_busy |-> sda_oe_n; endproperty
    property p_protect; $rose(prog_busy) |-> !prot_reg; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset state");
    a_drive_low: assert property (p_drive_low) else $error("drive value");
    a_mode_sticky: assert property (p_mode_sticky) else $error("mode");
    a_quiet_early: assert property (p_quiet_early) else $error("early");
    a_prog_len: assert property (p_prog_len) else $error("busy len");
    a_busy_on_stop: assert property (p_busy_on_stop) else $error("no stop");
    a_busy_quiet: assert property (p_busy_quiet) else $error("busy ack");
    a_protect: assert property (p_protect) else $error("protected");
    c_prog: cover property ($rose(prog_busy));
    c_ack: cover property ($fell(sda_oe_n) && bidir_mode);
    c_mode: cover property ($rose(bidir_mode));
endmodule : eep_i2c_page_assertions
bind eep_i2c_page eep_i2c_page_assertions #(.PROG_CYCLES(PROG_CYCLES))
    u_chk (.sys_clk(sys_clk), .resetn(resetn), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .transmit_only_clock_pin(transmit_only_clock_pin),
    .bidir_mode(bidir_mode), .prog_busy(prog_busy));

// ===== eep_master_model.sv
// Purpose: two-wire bus master model facing the EEPROM
// Assumes: both lines pulled up, so releasing means driving 1
// Notes:   10-cycle half bits leave margin for the pin synchronisers
`timescale 1ns/1ps
module eep_master_model (
    input wire logic sys_clk,
    input wire logic sda_w,
    output logic     scl_m,
    output logic     sda_m
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt
    // a=1,b=0 is a start (scl left low); a=0,b=1 is a stop
    task automatic cond(input logic a, input logic b);
        wt(5);
        sda_m = a;
        wt(5);
        scl_m = 1'b1;
        wt(10);
        sda_m = b;
        wt(10);
        scl_m = ~a;
    endtask : cond
    task automatic bit_io(input logic v, output logic r);
        wt(5);
        sda_m = v;
        wt(5);
        scl_m = 1'b1;
        wt(10);
        r = sda_w;
        scl_m = 1'b0;
    endtask : bit_io
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(~ack, r);
    endtask : rbyte
endmodule : eep_master_model

// ===== tb_top.sv
// Purpose: self-checking bench for the two-wire page-write EEPROM
// Assumes: pull-ups on both lines; random data from a fixed seed
// Notes:   programming shortened to 600 cycles so polling sees busy
`timescale 1ns/1ps
module tb_top;
    logic       sys_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       prot = 1'b1;
    logic       scl_m, sda_m, scl_o, scl_oe_n, sda_o, sda_oe_n;
    logic       bidir_mode, prog_busy, k;
    logic [7:0] d;
    logic [6:0] pa;
    logic [7:0] mem [128];
    int         seed = 23949;
    int         err_count = 0;
    int         comparisons = 0;
    int         cyc = 0;
    wire        scl_w = scl_m & (scl_oe_n | scl_o);
    wire        sda_w = sda_m & (sda_oe_n | sda_o);
    always #12.5 sys_clk = ~sys_clk;
    eep_master_model M (.sys_clk(sys_clk), .sda_w(sda_w), .scl_m(scl_m),
        .sda_m(sda_m));
    eep_i2c_page #(.PROG_CYCLES(600)) DUT (.sys_clk(sys_clk),
        .resetn(resetn), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .transmit_only_clock_pin(prot), .bidir_mode(bidir_mode),
        .prog_busy(prog_busy));
    task automatic conclude;
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : check
    function automatic logic [6:0] loc(input logic [6:0] a, input int i);
        return {a[6:4], a[3:0] + 4'(i)};
    endfunction : loc
    task automatic adr(input logic rw, input logic bad);
        d = {eep_pkg::DEV_TYPE_DEF ^ {bad, 3'h0}, 3'($random(seed)), rw};
        M.cond(1'b1, 1'b0);
        M.wbyte(d, k);
    endtask : adr
    task automatic pw(input logic [6:0] a, input int n);
        adr(1'b0, 1'b0);
        check(k, 8'h01);
        M.wbyte({1'b0, a}, k);
        check(k, 8'h01);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            M.wbyte(d, k);
            check(k, 8'h01);
            if (prot) mem[loc(a, i)] = d;
        end
        check(scl_oe_n, 8'h01);
        M.cond(1'b0, 1'b1);
        check(prog_busy, {7'h00, prot && n > 0});
        if (prog_busy) begin
            adr(1'b0, 1'b0);
            check(k, 8'h00);
            for (int j = 0; j < 8 && !k; j++) begin
                M.cond(1'b0, 1'b1);
                adr(1'b0, 1'b0);
            end
            check(k, 8'h01);
            M.cond(1'b0, 1'b1);
        end
    endtask : pw
    task automatic rd(input logic rnd, input logic [6:0] a, input int n);
        if (rnd) begin
            adr(1'b0, 1'b0);
            M.wbyte({1'b0, a}, k);
        end
        adr(1'b1, 1'b0);
        check(k, 8'h01);
        for (int i = 0; i < n; i++) begin
            M.rbyte(i < n - 1, d);
            check(d, mem[7'(a + 7'(i))]);
        end
        M.cond(1'b0, 1'b1);
    endtask : rd
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        M.cond(1'b1, 1'b0);
        M.cond(1'b0, 1'b1);
        check(bidir_mode, 8'h01);
        adr(1'b0, 1'b1);
        check(k, 8'h00);
        M.cond(1'b0, 1'b1);
        pw(7'h7E, 18);
        pw(7'h00, 16);
        rd(1'b1, 7'h7C, 6);
        rd(1'b0, 7'h02, 1);
        rd(1'b1, 7'h7F, 1);
        rd(1'b0, 7'h00, 1);
        prot = 1'b0;
        pw(7'h00, 3);
        prot = 1'b1;
        rd(1'b1, 7'h00, 3);
        pw(7'h40, 0);
        for (int t = 0; t < 3; t++) begin
            pa = 7'($random(seed));
            pw(pa, 16);
            rd(1'b1, {pa[6:4], 4'h0}, 16);
        end
        conclude();
    end
endmodule : tb_top
